// File: bench/ofd_apb_model.sv
// Purpose: apb requester standing in for the fetch and operand path
// Assumes: one transfer at a time, answer awaited with no fixed count
// Notes:   released address and data lines park at inverted last values
`timescale 1ns/1ns
module ofd_apb_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // setup, access until pready, then release and let one edge pass
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~wd;
        @(posedge pclk);
    endtask
endmodule

// File: bench/testbench.sv
// Purpose: self-checking bench for the operand format decoder
// Assumes: apb model drives the bus, seed fixed at 93
// Notes:   expectations computed in the bench, never read back from the dut
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    import ofd_pkg::*;
    localparam logic [31:0] CORNER [6] = '{32'h0A12_0000, 32'hD2FF_0000, 32'hF8FF_0000,
                                          32'hD200_0000, 32'h8F5E_0000, 32'h8FE5_0000};
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        data_exc;
    logic [4:0]  fmt;
    logic [31:0] rv;
    logic        er;
    int          err_total;
    int          tests_run;

    ofd_apb_model fm (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ofd_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .data_exc(data_exc), .fmt(fmt));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        fm.xfer(1'b1, a, d, rv, er);
    endtask

    task automatic rd(input logic [7:0] a);
        fm.xfer(1'b0, a, 32'h0, rv, er);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic logic [4:0] fmt_of(input logic [7:0] op);
        if (op[7:6] == 2'h0) return 5'h01;
        if (op[7:6] == 2'h1) return 5'h02;
        if (op[7:6] == 2'h3) return 5'h10;
        return (op[5:4] == 2'h0) ? 5'h04 : 5'h08;
    endfunction

    function automatic logic [19:0] dec_exp(input logic [31:0] i, input logic [31:0] ia,
                                            input logic [31:0] oc);
        logic [4:0] f;
        logic [2:0] l;
        logic       al;
        logic       sf;
        f = fmt_of(i[31:24]);
        l = f[0] ? ILEN_SHORT : (f[4] ? ILEN_LONG : ILEN_MID);
        al = (oc[19:18] == SZ_DOUBLE && oc[2:0] != 3'h0) || (oc[19:18] == SZ_HALF && oc[0])
            || (oc[19:18] == SZ_WORD && oc[1:0] != 2'h0);
        sf = (f[0] && !oc[20] && oc[19:18] == SZ_DOUBLE) || (f[3] && oc[19]);
        return {sf, al, i[31:24] == RR_IMM_OPC, i[23:16], ia[0], l, f};
    endfunction

    function automatic logic [31:0] len_exp(input logic [31:0] i, output logic [31:0] m);
        logic [8:0] l1;
        logic [8:0] l2;
        m = 32'h0;
        len_exp = 32'h0;
        l1 = i[28] ? 9'(i[23:20]) + 9'h1 : 9'(i[23:16]) + 9'h1;
        l2 = i[28] ? 9'(i[19:16]) + 9'h1 : l1;
        if (i[31:30] == 2'h3) begin
            m = 32'h01FF_01FF;
            len_exp = {7'h0, l2, 7'h0, l1};
        end
        if (i[31:28] == 4'h8) begin
            m = 32'h3E00_0000;
            len_exp = {2'h0, 5'(4'(i[19:16] - i[23:20])) + 5'h1, 25'h0};
        end
    endfunction

    initial begin
        #(40 * 20000);
        err_total++;
        wrap_up();
    end

    initial begin
        logic [31:0] i0;
        logic [31:0] src;
        logic [31:0] res;
        logic [31:0] lm;
        logic [31:0] le;
        logic [31:0] ia;
        logic [3:0]  zn;
        logic [3:0]  sg;
        logic        md;
        logic        ex;
        err_total = 0;
        tests_run = 0;
        presetn = 1'b0;
        rv = $urandom(93);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFD_CTRL);
        `CHK(rv, RST_WORD)
        `CHK(fmt, 5'h01)
        foreach (CORNER[k]) begin
            rd(8'h34 + 8'(k));
            `CHK({er, rv}, {1'b1, 32'h0})
        end
        $display("reset and unmapped test done");
        for (int k = 0; k < 40; k++) begin
            i0 = (k < 6) ? CORNER[k] : $urandom;
            ia = $urandom;
            src = $urandom & 32'h1F_FFFF;
            wr(OFD_INSTR0, i0);
            wr(OFD_IADDR, ia);
            wr(OFD_OPCHK, src);
            rd(OFD_DEC);
            `CHK(rv[19:0], dec_exp(i0, ia, src))
            `CHK(fmt, fmt_of(i0[31:24]))
            rd(OFD_LEN);
            le = len_exp(i0, lm);
            `CHK(rv & lm, le)
            `CHK(er, 1'b0)
        end
        $display("decode test done");
        for (int k = 0; k < 40; k++) begin
            md = k[0];
            zn = md ? ZONE_ASCII : ZONE_EBCDIC;
            wr(OFD_CTRL, {31'h0, md});
            for (int b = 0; b < 8; b++) src[4*b +: 4] = 4'($urandom % 10);
            if (k < 24) begin
                for (int b = 0; b < 4; b++) src[8*b+4 +: 4] = zn;
                if (k[1]) src[7:4] = 4'hA + 4'($urandom % 6);
                if (k == 20) src[11:8] = 4'hC;
                if (k == 23) src[7:4] = 4'h3;
                sg = (src[7:4] >= 4'hA) ? src[7:4] : SIGN_PLUS;
                ex = (k == 20) || (k == 23);
                wr(OFD_PACK_SRC, src);
                rd(OFD_PACK_RES);
                res = rv;
                le = {12'h0, src[27:24], src[19:16], src[11:8], src[3:0], sg};
            end else begin
                src[3:0] = 4'hA + 4'($urandom % 6);
                if (k == 38) src[19:16] = 4'hE;
                if (k == 39) src[3:0] = 4'h9;
                sg = src[3:0];
                ex = k >= 38;
                wr(OFD_UNPK_SRC, src);
                rd(OFD_UNPK_RES);
                res = rv;
                le = {zn, src[19:16], zn, src[15:12], zn, src[11:8], src[3:0], src[7:4]};
            end
            rd(OFD_CTRL);
            `CHK({rv[8], data_exc}, {ex, ex})
            if (!ex) begin
                `CHK(res, le)
                `CHK(rv[9], sg == SIGN_NEG_A || sg == SIGN_NEG_B)
            end else begin
                wr(OFD_CTRL, {23'h0, 1'b1, 7'h0, md});
                `CHK(data_exc, 1'b0)
            end
        end
        $display("conversion test done");
        for (int k = 0; k < 3; k++) begin
            ia = (k == 2) ? ($urandom % 30) + 1 : 31 * k;
            i0 = $urandom;
            src = $urandom;
            wr(OFD_GSEL, ia);
            wr(OFD_GDATA, i0);
            wr(OFD_GSEL, ia | 32'h100);
            wr(OFD_GDATA, src);
            wr(OFD_GSEL, ia);
            rd(OFD_GDATA);
            `CHK(rv, {i0[31:8], src[7:0]})
        end
        $display("general register test done");
        wrap_up();
    end
endmodule

// File: hw/ofd_decoder.sv
// Purpose: instruction format and decimal operand decoder behind APB
// Assumes: single clock pclk, async active-low presetn, APB slave
// Notes:   one wait state on every access, pslverr on unmapped offsets
//
// What this block does
// - unpacked byte: zone high nibble, digit low
// - zone 1111 for EBCDIC, 0101 for ASCII
// - unpacked sign from lowest byte zone
// - packed bytes hold two digits each
// - packed sign from lowest byte low nibble
// - 1011,1101 minus; 1010,1100,1110,1111 plus
// - one status bit selects ASCII or EBCDIC
// - decimal arithmetic uses packed operands only
// - convert unpacked to packed and back
// - register logical data one or four bytes
// - byte ops keep upper 24 bits unchanged
// - words word-aligned, halves half-aligned, bytes free
// - lengths 2, 4, 6; even start address
// - five formats: RR, RX, RS, SI, SS
// - length field holds true length minus one
// - RR: double in FP, word in general
// - some RR use both fields as immediate
// - RX moves at most a double word
// - RS first and third bound register group
// - SI: 8-bit immediate with byte or half
// - SS logical: equal lengths 1 to 256
// - SS decimal: independent lengths 1 to 16
// - 32 general registers of 32 bits
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module ofd_decoder
    import ofd_pkg::*;
#(
    parameter int NUM_GPR = 32,
    parameter int GPR_W   = 32
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             data_exc,
    output logic      [4:0]  fmt
);

    initial begin
        if (NUM_GPR != 32 || GPR_W != 32) begin
            $error("ofd_decoder serves only 32 registers of 32 bits");
        end
    end

    // nibble is not a decimal digit
    function automatic logic bad_digit(input logic [3:0] n);
        bad_digit = (n > DIGIT_MAX);
    endfunction

    // nibble is one of the six sign codes
    function automatic logic sign_ok(input logic [3:0] n);
        sign_ok = (n >= 4'hA);
    endfunction

    function automatic logic sign_neg(input logic [3:0] n);
        sign_neg = (n == SIGN_NEG_A) || (n == SIGN_NEG_B);
    endfunction

    // unpacked word (4 digits, sign in zone of low byte) to packed
    function automatic ofd_cvt_t pack_word(input logic [31:0] w, input logic asc);
        ofd_cvt_t   r;
        logic [3:0] zn;
        logic [3:0] sg;
        r  = '0;
        zn = w[7:4];
        sg = sign_ok(zn) ? zn : SIGN_PLUS;
        r.res = {12'h000, w[27:24], w[19:16], w[11:8], w[3:0], sg};
        r.exc = bad_digit(w[27:24]) | bad_digit(w[19:16]) | bad_digit(w[11:8])
              | bad_digit(w[3:0])
              | (!sign_ok(zn) && zn != (asc ? ZONE_ASCII : ZONE_EBCDIC));
        r.neg = sign_neg(sg);
        return r;
    endfunction

    // packed word (7 digits and sign) to unpacked low four digits
    function automatic ofd_cvt_t unpack_word(input logic [31:0] w, input logic asc);
        ofd_cvt_t   r;
        logic [3:0] zn;
        r  = '0;
        zn = asc ? ZONE_ASCII : ZONE_EBCDIC;
        r.res = {zn, w[19:16], zn, w[15:12], zn, w[11:8], w[3:0], w[7:4]};
        r.exc = !sign_ok(w[3:0]);
        for (int i = 1; i < 8; i++) begin
            r.exc = r.exc | bad_digit(w[4*i +: 4]);
        end
        r.neg = sign_neg(w[3:0]);
        return r;
    endfunction

    // registers
    logic [31:0]      instr0_ff;
    logic [31:0]      instr1_ff;
    logic [17:0]      iaddr_ff;
    logic [20:0]      opchk_ff;
    logic             ascii_ff;
    logic [31:0]      pack_ff;
    logic [31:0]      unpk_ff;
    logic             exc_ff;
    logic             neg_ff;
    logic [4:0]       gsel_ff;
    logic             gbyte_ff;
    logic [31:0]      prdata_ff;
    logic             pready_ff;
    logic             pslverr_ff;
    logic [4:0]       fmt_ff;
    logic [GPR_W-1:0] gpr_mem [NUM_GPR];

    // bus decode
    wire        acc_first = psel & penable & ~pready_ff;
    wire        acc_done  = psel & penable & pready_ff;
    wire        hit       = (paddr[1:0] == 2'h0) && (paddr <= OFD_GDATA);
    wire        wr_en     = acc_done & pwrite & hit;
    wire        wr_ctrl   = wr_en && paddr == OFD_CTRL;
    wire        wr_i0     = wr_en && paddr == OFD_INSTR0;
    wire        wr_i1     = wr_en && paddr == OFD_INSTR1;
    wire        wr_ia     = wr_en && paddr == OFD_IADDR;
    wire        wr_opc    = wr_en && paddr == OFD_OPCHK;
    wire        wr_pack   = wr_en && paddr == OFD_PACK_SRC;
    wire        wr_unpk   = wr_en && paddr == OFD_UNPK_SRC;
    wire        wr_gsel   = wr_en && paddr == OFD_GSEL;
    wire        wr_gdat   = wr_en && paddr == OFD_GDATA;

    // instruction decode
    wire [7:0]  opcode = instr0_ff[31:24];
    wire        is_rr  = opcode[7:6] == 2'b00;
    wire        is_rx  = opcode[7:6] == 2'b01;
    wire        is_rs  = opcode[7:6] == 2'b10 && opcode[5:4] == 2'b00;
    wire        is_si  = opcode[7:6] == 2'b10 && opcode[5:4] != 2'b00;
    wire        is_ss  = opcode[7:6] == 2'b11;
    wire        ss_dec = is_ss & opcode[4];
    wire [7:0]  lfield = instr0_ff[23:16];
    ofd_dec_t   dec;

    assign dec.fmt    = is_rr ? FMT_RR : is_rx ? FMT_RX : is_rs ? FMT_RS
                      : is_si ? FMT_SI : FMT_SS;
    assign dec.ilen   = is_rr ? ILEN_SHORT : is_ss ? ILEN_LONG : ILEN_MID;
    assign dec.imm    = instr0_ff[23:16];
    assign dec.rr_imm = is_rr && opcode == RR_IMM_OPC;
    assign dec.r1     = instr0_ff[23:20];
    assign dec.r3     = instr0_ff[19:16];
    assign dec.grp    = is_rs ? {1'b0, 4'(dec.r3 - dec.r1)} + 5'h01 : 5'h00;
    assign dec.len1   = !is_ss ? 9'h000
                      : ss_dec ? {5'h00, lfield[7:4]} + 9'h001
                      : {1'b0, lfield} + 9'h001;
    assign dec.len2   = !is_ss ? 9'h000
                      : ss_dec ? {5'h00, lfield[3:0]} + 9'h001
                      : {1'b0, lfield} + 9'h001;
    wire        odd_ia = iaddr_ff[0];

    // storage operand alignment and size limits
    wire [1:0]  op_sz  = opchk_ff[OPCHK_SZ_LSB +: 2];
    wire        op_fp  = opchk_ff[OPCHK_FP_BIT];
    wire [2:0]  op_lo  = opchk_ff[2:0];
    wire        a_flt  = (op_sz == SZ_HALF   && op_lo[0])
                      || (op_sz == SZ_WORD   && op_lo[1:0] != 2'h0)
                      || (op_sz == SZ_DOUBLE && op_lo != 3'h0);
    wire        s_flt  = (is_rr && !op_fp && op_sz == SZ_DOUBLE)
                      || (is_si && op_sz > SZ_HALF);

    // conversions
    ofd_cvt_t   pk_nxt;
    ofd_cvt_t   up_nxt;
    assign pk_nxt = pack_word(pwdata, ascii_ff);
    assign up_nxt = unpack_word(pwdata, ascii_ff);

    // read mux
    wire [31:0] gpr_rd = gpr_mem[gsel_ff];
    wire [31:0] dec_rd = {12'h000, s_flt, a_flt, dec.rr_imm, dec.imm,
                          odd_ia, dec.ilen, dec.fmt};
    wire [31:0] len_rd = {2'b00, dec.grp, dec.len2, 7'h00, dec.len1};
    logic [31:0] rd_mux;
    always_comb begin
        case (paddr)
            OFD_CTRL:     rd_mux = {22'h0, neg_ff, exc_ff, 7'h00, ascii_ff};
            OFD_INSTR0:   rd_mux = instr0_ff;
            OFD_INSTR1:   rd_mux = instr1_ff;
            OFD_IADDR:    rd_mux = {14'h0, iaddr_ff};
            OFD_DEC:      rd_mux = dec_rd;
            OFD_LEN:      rd_mux = len_rd;
            OFD_OPCHK:    rd_mux = {11'h0, opchk_ff};
            OFD_PACK_RES: rd_mux = pack_ff;
            OFD_UNPK_RES: rd_mux = unpk_ff;
            OFD_GSEL:     rd_mux = {23'h0, gbyte_ff, 3'h0, gsel_ff};
            OFD_GDATA:    rd_mux = gpr_rd;
            default:      rd_mux = RST_WORD;
        endcase
    end

    // apb handshake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= RST_WORD;
        end else begin
            pready_ff  <= acc_first;
            pslverr_ff <= acc_first & ~hit;
            if (acc_first) begin
                prdata_ff <= hit ? rd_mux : RST_WORD;
            end
        end
    end

    // control and instruction registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ascii_ff  <= RST_ASCII;
            instr0_ff <= RST_WORD;
            instr1_ff <= RST_WORD;
            iaddr_ff  <= 18'h00000;
            opchk_ff  <= 21'h000000;
            gsel_ff   <= 5'h00;
            gbyte_ff  <= 1'b0;
            fmt_ff    <= 5'h00;
        end else begin
            if (wr_ctrl) ascii_ff <= pwdata[CTRL_ASCII_BIT];
            if (wr_i0) instr0_ff <= pwdata;
            if (wr_i1) instr1_ff <= {16'h0000, pwdata[15:0]};
            if (wr_ia) iaddr_ff <= pwdata[17:0];
            if (wr_opc) opchk_ff <= pwdata[20:0];
            if (wr_gsel) begin
                gsel_ff  <= pwdata[4:0];
                gbyte_ff <= pwdata[GSEL_BYTE_BIT];
            end
            fmt_ff <= dec.fmt;
        end
    end

    // decimal conversion results with exception and sign flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pack_ff <= RST_WORD;
            unpk_ff <= RST_WORD;
            exc_ff  <= 1'b0;
            neg_ff  <= 1'b0;
        end else if (wr_pack) begin
            pack_ff <= pk_nxt.res;
            exc_ff  <= pk_nxt.exc;
            neg_ff  <= pk_nxt.neg;
        end else if (wr_unpk) begin
            unpk_ff <= up_nxt.res;
            exc_ff  <= up_nxt.exc;
            neg_ff  <= up_nxt.neg;
        end else if (wr_ctrl && pwdata[CTRL_EXC_BIT]) begin
            exc_ff  <= 1'b0;
        end
    end

    // general registers, byte mode touches low eight bits only
    always_ff @(posedge pclk) begin
        if (wr_gdat) begin
            if (gbyte_ff) gpr_mem[gsel_ff] <= {gpr_mem[gsel_ff][31:8], pwdata[7:0]};
            else gpr_mem[gsel_ff] <= pwdata;
        end
    end

    assign prdata   = prdata_ff;
    assign pready   = pready_ff;
    assign pslverr  = pslverr_ff;
    assign data_exc = exc_ff;
    assign fmt      = fmt_ff;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait;
        psel && penable && !pready;
    endsequence

    logic [31:0] gpr_old;
    assign gpr_old = gpr_mem[gsel_ff];

    chk_apb_wait: assert property (s_setup ##1 s_wait |=> pready)
        else $error("pready not raised after one wait state");
    chk_zone_ascii: assert property (wr_unpk && ascii_ff |=> unpk_ff[31:28] == ZONE_ASCII)
        else $error("ascii zone wrong");
    chk_zone_ebcdic: assert property (wr_unpk && !ascii_ff |=> unpk_ff[23:20] == ZONE_EBCDIC)
        else $error("ebcdic zone wrong");
    chk_unpk_sign: assert property (wr_unpk |=> unpk_ff[7:4] == $past(pwdata[3:0]))
        else $error("packed sign not moved to low zone");
    chk_pack_sign: assert property (wr_pack && pwdata[7:4] == SIGN_NEG_B |=> neg_ff && pack_ff[3:0] == SIGN_NEG_B)
        else $error("unpacked sign not taken from low zone");
    chk_bad_digit: assert property (wr_pack && pwdata[3:0] > DIGIT_MAX |=> data_exc)
        else $error("bad digit missed");
    chk_byte_keep: assert property (wr_gdat && gbyte_ff |=> gpr_old[31:8] == $past(gpr_old[31:8]))
        else $error("upper bits disturbed");
    chk_ss_logic: assert property (is_ss && !ss_dec |-> dec.len1 == dec.len2 && dec.len1 == {1'b0, lfield} + 9'h001)
        else $error("logical lengths differ");
    chk_ss_dec: assert property (ss_dec |-> dec.len1 <= SS_DEC_MAX && dec.len2 <= SS_DEC_MAX && dec.len1 != 9'h000)
        else $error("decimal length out of range");
    chk_ilen_map: assert property (is_rr |-> dec.ilen == ILEN_SHORT)
        else $error("rr length not two");
    chk_word_align: assert property (op_sz == SZ_WORD && op_lo[1:0] == 2'h2 |-> a_flt)
        else $error("misaligned word not flagged");
    chk_fmt_out: assert property (wr_i0 ##1 1'b1 |=> fmt == $past(dec.fmt))
        else $error("format output lags");

endmodule

// File: hw/ofd_pkg.sv
// Purpose: shared constants and types for the operand format decoder
// Assumes: APB register access, 32-bit data, byte addresses below 0x40
// Notes:   register offsets and field positions live here only
package ofd_pkg;

    // register byte offsets
    localparam logic [7:0] OFD_CTRL     = 8'h00;
    localparam logic [7:0] OFD_INSTR0   = 8'h04;
    localparam logic [7:0] OFD_INSTR1   = 8'h08;
    localparam logic [7:0] OFD_IADDR    = 8'h0C;
    localparam logic [7:0] OFD_DEC      = 8'h10;
    localparam logic [7:0] OFD_LEN      = 8'h14;
    localparam logic [7:0] OFD_OPCHK    = 8'h18;
    localparam logic [7:0] OFD_PACK_SRC = 8'h1C;
    localparam logic [7:0] OFD_PACK_RES = 8'h20;
    localparam logic [7:0] OFD_UNPK_SRC = 8'h24;
    localparam logic [7:0] OFD_UNPK_RES = 8'h28;
    localparam logic [7:0] OFD_GSEL     = 8'h2C;
    localparam logic [7:0] OFD_GDATA    = 8'h30;

    // field positions
    localparam int CTRL_ASCII_BIT = 0;
    localparam int CTRL_EXC_BIT   = 8;
    localparam int CTRL_NEG_BIT   = 9;
    localparam int GSEL_BYTE_BIT  = 8;
    localparam int OPCHK_SZ_LSB   = 18;
    localparam int OPCHK_FP_BIT   = 20;
    localparam int DEC_ODD_BIT    = 8;
    localparam int DEC_RRIMM_BIT  = 17;
    localparam int DEC_AFLT_BIT   = 18;
    localparam int DEC_SFLT_BIT   = 19;

    // reset values
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic        RST_ASCII = 1'b0;

    // zone and sign codes
    localparam logic [3:0] ZONE_EBCDIC = 4'hF;
    localparam logic [3:0] ZONE_ASCII  = 4'h5;
    localparam logic [3:0] SIGN_NEG_A  = 4'hB;
    localparam logic [3:0] SIGN_NEG_B  = 4'hD;
    localparam logic [3:0] SIGN_PLUS   = 4'hC;
    localparam logic [3:0] DIGIT_MAX   = 4'h9;

    // operand sizes and limits
    localparam logic [1:0] SZ_BYTE   = 2'h0;
    localparam logic [1:0] SZ_HALF   = 2'h1;
    localparam logic [1:0] SZ_WORD   = 2'h2;
    localparam logic [1:0] SZ_DOUBLE = 2'h3;
    localparam logic [8:0] SS_LOGIC_MAX = 9'h100;
    localparam logic [8:0] SS_DEC_MAX   = 9'h010;
    localparam logic [7:0] RR_IMM_OPC   = 8'h0A;
    localparam logic [2:0] ILEN_SHORT = 3'h2;
    localparam logic [2:0] ILEN_MID   = 3'h4;
    localparam logic [2:0] ILEN_LONG  = 3'h6;

    typedef enum logic [4:0] {
        FMT_RR = 5'b00001,
        FMT_RX = 5'b00010,
        FMT_RS = 5'b00100,
        FMT_SI = 5'b01000,
        FMT_SS = 5'b10000
    } ofd_fmt_t;

    typedef struct packed {
        ofd_fmt_t   fmt;
        logic [2:0] ilen;
        logic [7:0] imm;
        logic       rr_imm;
        logic [3:0] r1;
        logic [3:0] r3;
        logic [4:0] grp;
        logic [8:0] len1;
        logic [8:0] len2;
    } ofd_dec_t;

    typedef struct packed {
        logic [31:0] res;
        logic        exc;
        logic        neg;
    } ofd_cvt_t;

endpackage
